/* core/wfbd_map.svh */
// Word codes, field positions and counts of the field bitstream.
`ifndef WFBD_MAP_SVH
`define WFBD_MAP_SVH
`define WFBD_ONES 32'hFFFFFFFF
`define WFBD_FLD1_TAIL 32'hF4000000
`define WFBD_FLD2_TAIL 32'hF4100000
`define WFBD_EOS_TAIL 32'hC0FFFFFF
`define WFBD_CODE_M1C 8'h81
`define WFBD_CODE_M1L 8'h82
`define WFBD_CODE_M2C 8'h83
`define WFBD_CODE_M2L 8'h84
`define WFBD_CODE_ZERO 8'h8F
`define WFBD_CODE_HI 31
`define WFBD_CODE_LO 24
`define WFBD_BW_HI 23
`define WFBD_BW_LO 8
`define WFBD_LEAD_HI 7
`define WFBD_BW_NONE 16'h0000
`define WFBD_BLOCKS 6'h29
`define WFBD_VITC_LAST 2'h2
`endif

/* core/wfbd_pkg.sv */
// Types and code helpers shared by the stream parser and framer.
`include "wfbd_map.svh"
package wfbd_pkg;
  typedef enum logic [1:0] {
    MDL_M1_CHROMA = 2'h0,
    MDL_M1_LUMA = 2'h1,
    MDL_M2_CHROMA = 2'h2,
    MDL_M2_LUMA = 2'h3
  } wfbd_model_t;
  typedef enum logic [4:0] {
    PS_HUNT = 5'h01,
    PS_VITC = 5'h02,
    PS_HEAD = 5'h04,
    PS_DATA = 5'h08,
    PS_SKIP = 5'h10
  } wfbd_pstate_t;
  typedef enum logic [4:0] {
    FS_IDLE = 5'h01,
    FS_SECOND = 5'h02,
    FS_VITC = 5'h04,
    FS_HEAD = 5'h08,
    FS_DATA = 5'h10
  } wfbd_fstate_t;

  function automatic logic [7:0] wfbd_model_code(input wfbd_model_t m);
    wfbd_model_code = `WFBD_CODE_M1C + {6'h00, m};
  endfunction

  function automatic wfbd_model_t wfbd_code_model(input logic [7:0] c);
    logic [7:0] off;
    off = c - `WFBD_CODE_M1C;
    wfbd_code_model = wfbd_model_t'(off[1:0]);
  endfunction

  function automatic logic wfbd_code_kind(input logic [7:0] c);
    wfbd_code_kind = c >= `WFBD_CODE_M1C && c <= `WFBD_CODE_M2L;
  endfunction
endpackage

/* core/wfbd_enc_if.sv */
// Encode-side request and word stream between the top and the framer.
`timescale 1ns/1ps
interface wfbd_enc_if;
  import wfbd_pkg::*;
  logic hdr_valid, hdr_ready, hdr_field, hdr_field2, hdr_zero;
  wfbd_model_t hdr_model;
  logic [15:0] hdr_bw;
  logic [7:0] hdr_lead;
  logic [95:0] hdr_vitc;
  logic pay_valid, pay_ready, pay_last;
  logic [31:0] pay_data;
  logic out_valid, out_ready;
  logic [31:0] out_data;
  logic [5:0] blk_idx;
  modport framer(input hdr_valid, hdr_field, hdr_field2, hdr_zero,
    hdr_model, hdr_bw, hdr_lead, hdr_vitc, pay_valid, pay_last,
    pay_data, out_ready, output hdr_ready, pay_ready, out_valid,
    out_data, blk_idx);
  modport user(output hdr_valid, hdr_field, hdr_field2, hdr_zero,
    hdr_model, hdr_bw, hdr_lead, hdr_vitc, pay_valid, pay_last,
    pay_data, out_ready, input hdr_ready, pay_ready, out_valid,
    out_data, blk_idx);
endinterface

/* core/wfbd_framer.sv */
// Encode framer: turns field and block requests into aligned words.
`timescale 1ns/1ps
`include "wfbd_map.svh"
module wfbd_framer (
  input wire logic clk,
  input wire logic rst,
  wfbd_enc_if.framer eif
);
  import wfbd_pkg::*;
  wfbd_fstate_t st_q, st_d;
  logic fld_q, fld_d, f2_q, f2_d, zero_q, zero_d, ov_q, ov_d, adv;
  wfbd_model_t mdl_q, mdl_d;
  logic [15:0] bw_q, bw_d;
  logic [7:0] lead_q, lead_d, code;
  logic [95:0] vitc_q, vitc_d;
  logic [1:0] vc_q, vc_d;
  logic [5:0] blk_q, blk_d;
  logic [31:0] od_q, od_d;

  assign adv = !ov_q || eif.out_ready;
  assign eif.hdr_ready = st_q == FS_IDLE && adv;
  assign eif.pay_ready = st_q == FS_DATA && adv;
  assign eif.out_valid = ov_q;
  assign eif.out_data = od_q;
  assign eif.blk_idx = blk_q;
  // The code names the block's model, or the zero-data code for a zero block.
  assign code = zero_q ? `WFBD_CODE_ZERO : wfbd_model_code(mdl_q);

  always_comb begin
    st_d = st_q;
    fld_d = fld_q;
    f2_d = f2_q;
    zero_d = zero_q;
    mdl_d = mdl_q;
    bw_d = bw_q;
    lead_d = lead_q;
    vitc_d = vitc_q;
    vc_d = vc_q;
    blk_d = blk_q;
    od_d = od_q;
    ov_d = ov_q && !eif.out_ready;
    case (st_q)
      FS_IDLE: if (eif.hdr_valid && adv) begin
        fld_d = eif.hdr_field;
        f2_d = eif.hdr_field2;
        zero_d = eif.hdr_zero;
        mdl_d = eif.hdr_model;
        bw_d = eif.hdr_bw;
        lead_d = eif.hdr_lead;
        vitc_d = eif.hdr_vitc;
        vc_d = 2'h0;
        // Block position is implied by order, so it is only counted.
        blk_d = eif.hdr_field ? 6'h00 : 6'(blk_q + 6'h01);
        ov_d = 1'b1;
        od_d = `WFBD_ONES;
        st_d = FS_SECOND;
      end
      FS_SECOND: if (adv) begin
        ov_d = 1'b1;
        if (fld_q) begin
          od_d = f2_q ? `WFBD_FLD2_TAIL : `WFBD_FLD1_TAIL;
          st_d = FS_VITC;
        end else begin
          od_d = {code, bw_q, lead_q};
          st_d = zero_q ? FS_IDLE : FS_DATA;
        end
      end
      FS_VITC: if (adv) begin
        ov_d = 1'b1;
        od_d = vitc_q[95:64];
        vitc_d = {vitc_q[63:0], 32'h00000000};
        vc_d = 2'(vc_q + 2'h1);
        if (vc_q == `WFBD_VITC_LAST) st_d = FS_HEAD;
      end
      FS_HEAD: if (adv) begin
        ov_d = 1'b1;
        od_d = {wfbd_model_code(mdl_q), bw_q, lead_q};
        st_d = zero_q ? FS_IDLE : FS_DATA;
      end
      FS_DATA: if (eif.pay_valid && adv) begin
        ov_d = 1'b1;
        od_d = eif.pay_data;
        if (eif.pay_last) st_d = FS_IDLE;
      end
      default: st_d = FS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= FS_IDLE;
      {fld_q, f2_q, zero_q, ov_q} <= 4'h0;
      mdl_q <= MDL_M1_CHROMA;
      bw_q <= 16'h0000;
      lead_q <= 8'h00;
      vitc_q <= 96'h0;
      vc_q <= 2'h0;
      blk_q <= 6'h00;
      od_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      {fld_q, f2_q, zero_q, ov_q} <= {fld_d, f2_d, zero_d, ov_d};
      mdl_q <= mdl_d;
      bw_q <= bw_d;
      lead_q <= lead_d;
      vitc_q <= vitc_d;
      vc_q <= vc_d;
      blk_q <= blk_d;
      od_q <= od_d;
    end
  end

  a_enc_mark_first: assert property (@(posedge clk) disable iff (rst)
    eif.hdr_valid && eif.hdr_ready |=> ov_q && od_q == `WFBD_ONES)
    else $error("delimiter does not open with an all-ones word");
  a_enc_no_eos: assert property (@(posedge clk) disable iff (rst)
    st_q == FS_SECOND && adv |=> od_q != `WFBD_EOS_TAIL)
    else $error("framer emitted an end-of-sequence delimiter");
endmodule // wfbd_framer

/* core/wfbd_codec_stream.sv */
// Field bitstream delimiter parser (decode) and framer wrapper (encode).
// ---------------------------------------------------------------------
// Summary of operation
// - Delimiters start on 32-bit word boundaries.
// - Field-one code starts first-field data.
// - Field-two code starts second-field data.
// - Field start resets entropy decoder, processing.
// - One field-start code alone separates fields.
// - Field code picks field identity output.
// - Twelve-byte timecode slot follows field start.
// - First block carries 8-bit type, no delimiter.
// - Later blocks open with five block codes.
// - Block start resets the entropy decoder.
// - Block position tracked by counting only.
// - Exactly 41 block starts per field.
// - Block code selects coding model, table.
// - Zero-data block: ignore all, treat zero.
// - Any block code may become zero-data; the first block of a field keeps a model code.
// - Encoder sends blocks in fixed order.
// - End code never appended to encoded output.
// - Zero bin width discards block data.
// - Payload padded with ones to words.
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`include "wfbd_map.svh"
module wfbd_codec_stream (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic IN_VALID,
  input wire logic [31:0] IN_DATA,
  output logic IN_READY,
  output logic DEC_RESET,
  output logic IN_FIELD,
  output logic FIELD_ID,
  output wfbd_pkg::wfbd_model_t DEC_MODEL,
  output logic ZERO_BLOCK,
  output logic [15:0] BIN_WIDTH,
  output logic [5:0] BLOCK_IDX,
  output logic PAY_VALID,
  output logic PAY_LEAD,
  output logic [31:0] PAY_DATA,
  output logic [95:0] VITC_OUT,
  output logic VITC_VALID,
  output logic EOS_SEEN,
  output logic COUNT_ERR,
  input wire logic HDR_VALID,
  input wire logic HDR_FIELD,
  input wire logic HDR_FIELD2,
  input wire wfbd_pkg::wfbd_model_t HDR_MODEL,
  input wire logic HDR_ZERO,
  input wire logic [15:0] HDR_BW,
  input wire logic [7:0] HDR_LEAD,
  input wire logic [95:0] HDR_VITC,
  output logic HDR_READY,
  input wire logic PAY_IN_VALID,
  input wire logic [31:0] PAY_IN_DATA,
  input wire logic PAY_IN_LAST,
  output logic PAY_IN_READY,
  output logic ENC_VALID,
  output logic [31:0] ENC_DATA,
  input wire logic ENC_READY,
  output logic [5:0] ENC_BLOCK_IDX
);
  import wfbd_pkg::*;

  // ---------------------------------------------------------------
  // Encode path
  // ---------------------------------------------------------------
  wfbd_enc_if eif ();

  assign eif.hdr_valid = HDR_VALID;
  assign eif.hdr_field = HDR_FIELD;
  assign eif.hdr_field2 = HDR_FIELD2;
  assign eif.hdr_model = HDR_MODEL;
  assign eif.hdr_zero = HDR_ZERO;
  assign eif.hdr_bw = HDR_BW;
  assign eif.hdr_lead = HDR_LEAD;
  assign eif.hdr_vitc = HDR_VITC;
  assign eif.pay_valid = PAY_IN_VALID;
  assign eif.pay_data = PAY_IN_DATA;
  assign eif.pay_last = PAY_IN_LAST;
  assign eif.out_ready = ENC_READY;
  assign HDR_READY = eif.hdr_ready;
  assign PAY_IN_READY = eif.pay_ready;
  assign ENC_VALID = eif.out_valid;
  assign ENC_DATA = eif.out_data;
  assign ENC_BLOCK_IDX = eif.blk_idx;

  wfbd_framer u_framer (
    .clk(CLOCK),
    .rst(RST),
    .eif(eif)
  );

  // ---------------------------------------------------------------
  // Decode parser state
  // ---------------------------------------------------------------
  wfbd_pstate_t st_q, st_d;
  wfbd_model_t model_q, model_d;
  logic marker_q, marker_d;
  logic inf_q, inf_d;
  logic field_q, field_d;
  logic zero_q, zero_d;
  logic [15:0] bw_q, bw_d;
  logic [5:0] blk_q, blk_d;
  logic [1:0] vcnt_q, vcnt_d;
  logic [95:0] vitc_q, vitc_d;
  logic pv_q, pv_d, pl_q, pl_d;
  logic [31:0] pd_q, pd_d;
  logic rst_q, rst_d, vv_q, vv_d, eos_q, eos_d, err_q, err_d;

  logic [31:0] w;
  logic [7:0] code;
  logic [15:0] wbw;
  logic is_sof, is_eos, is_sob, is_ones, is_tail, take, flush, hd_zero;

  // ---------------------------------------------------------------
  // Word classification
  // ---------------------------------------------------------------
  // A delimiter is an all-ones word followed by its tail word, both
  // word aligned, so every compare is at a fixed position in the word.
  always_comb begin
    w = IN_DATA;
    code = w[`WFBD_CODE_HI:`WFBD_CODE_LO];
    wbw = w[`WFBD_BW_HI:`WFBD_BW_LO];
    is_ones = w == `WFBD_ONES;
    is_sof = w == `WFBD_FLD1_TAIL || w == `WFBD_FLD2_TAIL;
    is_eos = w == `WFBD_EOS_TAIL;
    is_sob = st_q != PS_HUNT &&
      (wfbd_code_kind(code) || code == `WFBD_CODE_ZERO);
    is_tail = is_sof || is_eos || is_sob || is_ones;
    hd_zero = code == `WFBD_CODE_ZERO || wbw == `WFBD_BW_NONE;
  end

  // A held all-ones word that turns out to be payload is released
  // first; the word behind it is refused for that one cycle.
  assign flush = IN_VALID && marker_q && !is_tail;
  assign IN_READY = !flush;
  assign take = IN_VALID && !flush;

  // ---------------------------------------------------------------
  // Parser next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    model_d = model_q;
    marker_d = marker_q;
    inf_d = inf_q;
    field_d = field_q;
    zero_d = zero_q;
    bw_d = bw_q;
    blk_d = blk_q;
    vcnt_d = vcnt_q;
    vitc_d = vitc_q;
    pd_d = pd_q;
    pv_d = 1'b0;
    pl_d = 1'b0;
    rst_d = 1'b0;
    vv_d = 1'b0;
    eos_d = 1'b0;
    err_d = 1'b0;
    if (flush) begin
      marker_d = 1'b0;
      if (st_q == PS_DATA) begin
        pv_d = 1'b1;
        pd_d = `WFBD_ONES;
      end
    end else if (take && marker_q) begin
      marker_d = 1'b0;
      if (is_sof) begin
        rst_d = 1'b1;
        err_d = inf_q && blk_q != `WFBD_BLOCKS;
        field_d = w == `WFBD_FLD2_TAIL;
        inf_d = 1'b1;
        blk_d = 6'h00;
        vcnt_d = 2'h0;
        st_d = PS_VITC;
      end else if (is_eos) begin
        eos_d = 1'b1;
        err_d = inf_q && blk_q != `WFBD_BLOCKS;
        inf_d = 1'b0;
        st_d = PS_HUNT;
      end else if (is_sob) begin
        rst_d = 1'b1;
        err_d = blk_q == `WFBD_BLOCKS;
        if (blk_q != `WFBD_BLOCKS) blk_d = 6'(blk_q + 6'h01);
        if (code != `WFBD_CODE_ZERO) model_d = wfbd_code_model(code);
        bw_d = hd_zero ? `WFBD_BW_NONE : wbw;
        zero_d = hd_zero;
        st_d = hd_zero ? PS_SKIP : PS_DATA;
        pv_d = !hd_zero;
        pl_d = !hd_zero;
        pd_d = w;
      end else begin
        marker_d = 1'b1;
        if (st_q == PS_DATA) begin
          pv_d = 1'b1;
          pd_d = `WFBD_ONES;
        end
      end
    end else if (take) begin
      case (st_q)
        PS_VITC: begin
          vitc_d = {vitc_q[63:0], w};
          vcnt_d = 2'(vcnt_q + 2'h1);
          if (vcnt_q == `WFBD_VITC_LAST) begin
            vv_d = 1'b1;
            st_d = PS_HEAD;
          end
        end
        PS_HEAD: begin
          err_d = !wfbd_code_kind(code);
          model_d = wfbd_code_model(code);
          zero_d = wbw == `WFBD_BW_NONE;
          bw_d = wbw;
          st_d = (wbw == `WFBD_BW_NONE) ? PS_SKIP : PS_DATA;
          pv_d = wbw != `WFBD_BW_NONE;
          pl_d = wbw != `WFBD_BW_NONE;
          pd_d = w;
        end
        PS_DATA: begin
          if (is_ones) begin
            marker_d = 1'b1;
          end else begin
            pv_d = 1'b1;
            pd_d = w;
          end
        end
        PS_SKIP, PS_HUNT: begin
          if (is_ones) marker_d = 1'b1;
        end
        default: st_d = PS_HUNT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Parser registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_q <= PS_HUNT;
      model_q <= MDL_M1_CHROMA;
      marker_q <= 1'b0;
      inf_q <= 1'b0;
      field_q <= 1'b0;
      zero_q <= 1'b0;
      bw_q <= 16'h0000;
      blk_q <= 6'h00;
      vcnt_q <= 2'h0;
      vitc_q <= 96'h0;
      pd_q <= 32'h00000000;
      pv_q <= 1'b0;
      pl_q <= 1'b0;
      rst_q <= 1'b0;
      vv_q <= 1'b0;
      eos_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      model_q <= model_d;
      marker_q <= marker_d;
      inf_q <= inf_d;
      field_q <= field_d;
      zero_q <= zero_d;
      bw_q <= bw_d;
      blk_q <= blk_d;
      vcnt_q <= vcnt_d;
      vitc_q <= vitc_d;
      pd_q <= pd_d;
      pv_q <= pv_d;
      pl_q <= pl_d;
      rst_q <= rst_d;
      vv_q <= vv_d;
      eos_q <= eos_d;
      err_q <= err_d;
    end
  end

  assign DEC_RESET = rst_q;
  assign IN_FIELD = inf_q;
  assign FIELD_ID = field_q;
  assign DEC_MODEL = model_q;
  assign ZERO_BLOCK = zero_q;
  assign BIN_WIDTH = bw_q;
  assign BLOCK_IDX = blk_q;
  assign PAY_VALID = pv_q;
  assign PAY_LEAD = pl_q;
  assign PAY_DATA = pd_q;
  assign VITC_OUT = vitc_q;
  assign VITC_VALID = vv_q;
  assign EOS_SEEN = eos_q;
  assign COUNT_ERR = err_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_sof_restart: assert property (
    take && marker_q && is_sof |=> DEC_RESET && IN_FIELD &&
      BLOCK_IDX == 6'h00 ##1 !DEC_RESET)
    else $error("field start did not restart the parser");
  a_field_identity: assert property (
    take && marker_q && is_sof |=> FIELD_ID == $past(w[20]))
    else $error("field identity does not follow the field code");
  a_vitc_slot: assert property (
    VITC_VALID |-> $past(st_q) == PS_VITC &&
      $past(vcnt_q) == `WFBD_VITC_LAST && st_q == PS_HEAD)
    else $error("timecode slot was not three words");
  a_sob_reset: assert property (
    take && marker_q && is_sob |=> DEC_RESET)
    else $error("block start did not reset the entropy decoder");
  a_block_count: assert property (
    take && marker_q && is_sob && blk_q != `WFBD_BLOCKS |=>
      BLOCK_IDX == $past(blk_q) + 6'h01)
    else $error("block index did not advance by one");
  a_count_error: assert property (
    take && marker_q && (is_sof || is_eos) && inf_q &&
      blk_q != `WFBD_BLOCKS |=> COUNT_ERR)
    else $error("short field not flagged");
  a_model_select: assert property (
    take && marker_q && is_sob && code == `WFBD_CODE_M2L && !hd_zero |=>
      DEC_MODEL == MDL_M2_LUMA && !ZERO_BLOCK)
    else $error("block code did not select its model");
  a_zero_silent: assert property (
    st_q == PS_SKIP && !marker_q |-> !pv_d ##1 !PAY_VALID)
    else $error("payload passed inside a zero block");
  a_bin_zero: assert property (
    take && marker_q && is_sob && wbw == `WFBD_BW_NONE |=>
      ZERO_BLOCK && st_q == PS_SKIP)
    else $error("zero bin width did not discard the block");
  a_flush_ones: assert property (
    flush && st_q == PS_DATA |-> !IN_READY ##1
      PAY_VALID && PAY_DATA == `WFBD_ONES && !marker_q)
    else $error("held padding word was lost");

  c_field_start: cover property (take && marker_q && is_sof);
  c_zero_block: cover property (take && marker_q && is_sob && hd_zero);
  c_end_seq: cover property (EOS_SEEN && !COUNT_ERR);
  c_flush: cover property (flush && st_q == PS_DATA);
endmodule // wfbd_codec_stream

/* testbench/wfbd_host_model.sv */
// Host model that feeds decode words and drains encoded words.
`timescale 1ns/1ps
module wfbd_host_model (
  input wire logic CLOCK,
  input wire logic RST,
  output logic IN_VALID,
  output logic [31:0] IN_DATA,
  input wire logic IN_READY,
  input wire logic ENC_VALID,
  input wire logic [31:0] ENC_DATA,
  output logic ENC_READY
);
  logic [31:0] enc_q[$];
  int stuck = 0;
  initial begin
    IN_VALID = 1'b0;
    IN_DATA = 32'h00000000;
  end
  // Whole words only, so every delimiter lands on a word boundary.
  task automatic send(input logic [31:0] w);
    int n;
    IN_VALID <= 1'b1;
    IN_DATA <= w;
    n = 0;
    @(negedge CLOCK);
    while (IN_READY !== 1'b1 && n < 64) begin
      n++;
      @(negedge CLOCK);
    end
    if (n == 64) stuck++;
    @(posedge CLOCK);
  endtask
  // A released line shows the inverse, never a stale word.
  task automatic idle();
    IN_VALID <= 1'b0;
    IN_DATA <= ~IN_DATA;
    @(posedge CLOCK);
  endtask
  // Random stalls on the drain side test the hold of the output word.
  always @(posedge CLOCK) begin
    ENC_READY <= ($urandom % 4) != 0;
    if (!RST && ENC_VALID === 1'b1 && ENC_READY === 1'b1)
      enc_q.push_back(ENC_DATA);
  end
endmodule // wfbd_host_model

/* testbench/tb_wfbd_codec_stream.sv */
// Self-checking bench for the field bitstream parser and framer.
`timescale 1ns/1ps
`include "wfbd_map.svh"
module tb_wfbd_codec_stream;
  import wfbd_pkg::*;
  typedef logic [127:0] wfbd_tb_word_t;
  logic clock, rst, in_valid, in_ready, dec_reset, in_field, field_id;
  logic zero_block, pay_valid, pay_lead, vitc_valid, eos_seen, count_err;
  logic hdr_valid, hdr_field, hdr_field2, hdr_zero, hdr_ready;
  logic pay_in_valid, pay_in_last, pay_in_ready, enc_valid, enc_ready;
  logic [31:0] in_data, pay_data, pay_in_data, enc_data;
  logic [15:0] bin_width, hdr_bw;
  logic [5:0] block_idx, enc_block_idx;
  logic [7:0] hdr_lead;
  logic [95:0] vitc_out, hdr_vitc;
  wfbd_model_t dec_model, hdr_model, mdl;
  wfbd_tb_word_t rec_e[$], rec_g[$], lead_e[$], lead_g[$], pay_e[$];
  wfbd_tb_word_t pay_g[$], tc_e[$], tc_g[$], enc_e[$], enc_g[$];
  int bad_count = 0, samples_checked = 0, n_rst = 0, n_eos = 0, n_err = 0;
  int blk;
  wfbd_codec_stream dut_u (.CLOCK(clock), .RST(rst), .IN_VALID(in_valid),
    .IN_DATA(in_data), .IN_READY(in_ready), .DEC_RESET(dec_reset),
    .IN_FIELD(in_field), .FIELD_ID(field_id), .DEC_MODEL(dec_model),
    .ZERO_BLOCK(zero_block), .BIN_WIDTH(bin_width),
    .BLOCK_IDX(block_idx), .PAY_VALID(pay_valid), .PAY_LEAD(pay_lead),
    .PAY_DATA(pay_data), .VITC_OUT(vitc_out), .VITC_VALID(vitc_valid),
    .EOS_SEEN(eos_seen), .COUNT_ERR(count_err), .HDR_VALID(hdr_valid),
    .HDR_FIELD(hdr_field), .HDR_FIELD2(hdr_field2),
    .HDR_MODEL(hdr_model), .HDR_ZERO(hdr_zero), .HDR_BW(hdr_bw),
    .HDR_LEAD(hdr_lead), .HDR_VITC(hdr_vitc), .HDR_READY(hdr_ready),
    .PAY_IN_VALID(pay_in_valid), .PAY_IN_DATA(pay_in_data),
    .PAY_IN_LAST(pay_in_last), .PAY_IN_READY(pay_in_ready),
    .ENC_VALID(enc_valid), .ENC_DATA(enc_data), .ENC_READY(enc_ready),
    .ENC_BLOCK_IDX(enc_block_idx));
  wfbd_host_model host_u (.CLOCK(clock), .RST(rst), .IN_VALID(in_valid),
    .IN_DATA(in_data), .IN_READY(in_ready), .ENC_VALID(enc_valid),
    .ENC_DATA(enc_data), .ENC_READY(enc_ready));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input wfbd_tb_word_t e,
    input wfbd_tb_word_t g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cmp_q(input string nm, ref wfbd_tb_word_t e[$],
    ref wfbd_tb_word_t g[$]);
    check({nm, " count"}, e.size(), g.size());
    for (int i = 0; i < e.size() && i < g.size(); i++) check(nm, e[i], g[i]);
  endtask
  task automatic hs(input logic pay);
    int n = 0;
    @(negedge clock);
    while ((pay ? pay_in_ready : hdr_ready) !== 1'b1 && n < 64) begin
      n++;
      @(negedge clock);
    end
    if (n == 64) begin
      bad_count++;
      summarize();
    end
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (host_u.stuck != 0) begin
      bad_count++;
      summarize();
    end
    if (!rst) begin
      if (dec_reset === 1'b1) n_rst++;
      if (dec_reset === 1'b1 && block_idx !== 6'h00)
        rec_g.push_back({block_idx, zero_block});
      if (pay_valid === 1'b1 && pay_lead === 1'b1)
        lead_g.push_back({dec_model, bin_width, pay_data[7:0]});
      if (pay_valid === 1'b1 && pay_lead !== 1'b1) pay_g.push_back(pay_data);
      if (vitc_valid === 1'b1) tc_g.push_back({field_id, vitc_out});
      if (eos_seen === 1'b1) n_eos++;
      if (count_err === 1'b1) n_err++;
    end
  end
  // ------------------------------------------------------------------
  // Decode and encode stream builders
  // ------------------------------------------------------------------
  task automatic dec_block(input logic [7:0] code, input logic first);
    logic [15:0] bw;
    logic [7:0] ld;
    logic zero;
    logic [31:0] w;
    int n;
    bw = ($urandom % 8 == 0) ? 16'h0000 : 16'($urandom);
    ld = 8'($urandom);
    zero = code == `WFBD_CODE_ZERO || bw == `WFBD_BW_NONE;
    if (code != `WFBD_CODE_ZERO) mdl = wfbd_model_t'(code[1:0] - 2'h1);
    if (!first) host_u.send(`WFBD_ONES);
    host_u.send({code, bw, ld});
    if (!first) rec_e.push_back({6'(blk), zero});
    if (!zero) lead_e.push_back({mdl, bw, ld});
    n = 1 + $urandom % 3;
    for (int i = 0; i < n; i++) begin
      w = {1'b0, 31'($urandom)};
      // An all-ones pad word mid-block forces the flush stall.
      if (!zero && i == 0 && n > 1 && $urandom % 2 == 1) w = `WFBD_ONES;
      host_u.send(w);
      if (!zero) pay_e.push_back(w);
    end
  endtask
  task automatic dec_field(input logic f2, input int nblk);
    logic [95:0] tc;
    logic [7:0] c;
    tc = {$urandom, $urandom, $urandom};
    host_u.send(`WFBD_ONES);
    host_u.send(f2 ? `WFBD_FLD2_TAIL : `WFBD_FLD1_TAIL);
    host_u.send(tc[95:64]);
    host_u.send(tc[63:32]);
    host_u.send(tc[31:0]);
    tc_e.push_back({f2, tc});
    blk = 0;
    dec_block(8'h81 + 8'($urandom % 4), 1'b1);
    for (blk = 1; blk <= nblk; blk++) begin
      c = ($urandom % 5 == 4) ? `WFBD_CODE_ZERO : 8'h81 + 8'($urandom % 4);
      dec_block(c, 1'b0);
    end
  endtask
  task automatic enc_block(input logic fld, input logic f2,
    input logic [7:0] code);
    logic [15:0] bw;
    logic [7:0] ld;
    logic [95:0] tc;
    logic zero;
    logic [31:0] w;
    int n;
    zero = code == `WFBD_CODE_ZERO;
    bw = zero ? 16'h0000 : 16'($urandom | 1);
    ld = zero ? 8'h00 : 8'($urandom);
    tc = {$urandom, $urandom, $urandom};
    @(posedge clock);
    hdr_valid <= 1'b1;
    hdr_field <= fld;
    hdr_field2 <= f2;
    hdr_zero <= zero;
    hdr_model <= wfbd_model_t'(code[1:0] - 2'h1);
    hdr_bw <= bw;
    hdr_lead <= ld;
    hdr_vitc <= tc;
    hs(1'b0);
    hdr_valid <= 1'b0;
    enc_e.push_back(`WFBD_ONES);
    if (fld) begin
      enc_e.push_back(f2 ? `WFBD_FLD2_TAIL : `WFBD_FLD1_TAIL);
      enc_e.push_back(tc[95:64]);
      enc_e.push_back(tc[63:32]);
      enc_e.push_back(tc[31:0]);
    end
    enc_e.push_back({code, bw, ld});
    n = zero ? 0 : 1 + $urandom % 3;
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      pay_in_valid <= 1'b1;
      pay_in_data <= w;
      pay_in_last <= i == n - 1;
      hs(1'b1);
      enc_e.push_back(w);
    end
    pay_in_valid <= 1'b0;
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(8));
    rst = 1'b1;
    {hdr_valid, hdr_field, hdr_field2, hdr_zero} = 4'h0;
    {pay_in_valid, pay_in_last} = 2'h0;
    hdr_model = MDL_M1_CHROMA;
    {hdr_bw, hdr_lead, hdr_vitc, pay_in_data} = '0;
    mdl = MDL_M1_CHROMA;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("reset outs", 128'hC, {in_field, block_idx, dec_reset, in_ready,
      hdr_ready, pay_in_ready, enc_valid});
    $display("test reset done");
    @(posedge clock);
    host_u.send(32'h12345678);
    host_u.send(32'h00ABCDEF);
    dec_field(1'b0, 41);
    dec_field(1'b1, 3);
    dec_field(1'b0, 41);
    host_u.send(`WFBD_ONES);
    host_u.send(`WFBD_EOS_TAIL);
    host_u.idle();
    repeat (4) @(posedge clock);
    cmp_q("block index", rec_e, rec_g);
    cmp_q("model bw lead", lead_e, lead_g);
    cmp_q("payload", pay_e, pay_g);
    cmp_q("timecode field", tc_e, tc_g);
    check("decoder resets", 3 + 85, n_rst);
    check("count errors", 1, n_err);
    check("end seen", 1, n_eos);
    check("in field", 0, in_field);
    $display("test decode done");
    for (int f = 0; f < 2; f++) begin
      enc_block(1'b1, f[0], 8'h81 + 8'($urandom % 4));
      for (int b = 0; b < 41; b++)
        enc_block(1'b0, 1'b0, ($urandom % 5 == 4) ? `WFBD_CODE_ZERO :
          8'h81 + 8'($urandom % 4));
    end
    for (int i = 0; i < 2000 && host_u.enc_q.size() < enc_e.size(); i++)
      @(posedge clock);
    repeat (8) @(posedge clock);
    foreach (host_u.enc_q[i]) enc_g.push_back(host_u.enc_q[i]);
    cmp_q("encoded words", enc_e, enc_g);
    check("enc block idx", `WFBD_BLOCKS, enc_block_idx);
    $display("test encode done");
    summarize();
  end
endmodule // tb_wfbd_codec_stream
